// ---- hw/pscc_ctrl_reg.sv ----
// Speed fallback and MAC clock control register with its management access.
module pscc_ctrl_reg (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_n,
  input wire logic [4:0] phy_addr,
  input wire logic strap_config_1,
  input wire logic strap_config_0,
  input wire logic an_enable,
  input wire logic adv_1000,
  input wire logic adv_100,
  input wire logic adv_10,
  input wire logic attempt_fail,
  input wire logic link_restart,
  input wire logic link_up,
  input wire logic link_is_1000,
  input wire logic link_is_100,
  input wire logic [2:0] retry_limit,
  output logic [15:0] ctrl_word,
  output logic [2:0] speed_target,
  output logic [1:0] rx_clk_rate,
  output logic [1:0] tx_clk_rate
);

  // Register and its next value.
  logic [15:0] ctrl_r, ctrl_nxt;
  // Write event crossing from the management clock.
  logic wr_s1_r, wr_s2_r, wr_s3_r;
  logic mdc_wr_tgl;
  logic [15:0] mdc_wr_word;
  // Mirror crossing toward the management clock.
  logic [15:0] shadow_r;
  logic mir_req_r, ack_s1_r, ack_s2_r;
  logic mdc_ack;
  // Strap pins, three stages each.
  logic [1:0] strap_s1_r, strap_s2_r, strap_s3_r, strap_r;
  logic [2:0] strap_cnt_r;
  logic strap_done_r;
  // Fallback controller.
  pscc_pkg::pscc_speed_t spd_r, spd_nxt;
  logic [2:0] tries_r, tries_nxt;
  // Clock rate selection.
  pscc_pkg::pscc_rate_t rx_r, tx_r;
  // Marks the first enabled edge after reset, for checking only.
  logic seen_r;

  // Field decode of the live register.
  wire fb100_en = ctrl_r[pscc_pkg::BIT_FB100];
  wire fb10_en = ctrl_r[pscc_pkg::BIT_FB10];
  wire [2:0] clk_sel = ctrl_r[pscc_pkg::SEL_MSB:pscc_pkg::SEL_LSB];
  wire wr_apply = wr_s2_r ^ wr_s3_r;
  wire strap_fb100 = (strap_r == pscc_pkg::STRAP_FB100_CODE);
  wire strap_load = !strap_done_r && (strap_cnt_r == pscc_pkg::STRAP_SETTLE);
  wire mir_idle = (ack_s2_r == mir_req_r);
  wire mir_send = mir_idle && (shadow_r != ctrl_r);
  // Writable bits merged under the mask; reserved bits stay at reset values.
  wire [15:0] wr_merge = (ctrl_r & ~pscc_pkg::WR_MASK) | (mdc_wr_word & pscc_pkg::WR_MASK);
  wire [15:0] strap_merge = {ctrl_r[15:12], strap_fb100, ctrl_r[10:0]};
  wire can_100 = fb100_en && adv_100;
  wire can_10 = fb10_en && adv_10;
  wire retry_left = (tries_r < retry_limit);
  wire fail_ev = an_enable && !link_restart && attempt_fail && !link_up;
  wire pscc_pkg::pscc_speed_t top_spd = adv_1000 ? pscc_pkg::PSCC_SPD_1000 :
    (adv_100 ? pscc_pkg::PSCC_SPD_100 : pscc_pkg::PSCC_SPD_10);
  // Rates while linked follow the line, except the gigabit transmit clock, which the select code sets; without a link the select code rules.
  wire pscc_pkg::pscc_rate_t rx_link = link_is_1000 ? pscc_pkg::PSCC_125 :
    (link_is_100 ? pscc_pkg::PSCC_25 : pscc_pkg::PSCC_2P5);
  wire pscc_pkg::pscc_rate_t tx_link = link_is_1000 ? pscc_pkg::tx_gig(clk_sel) :
    (link_is_100 ? pscc_pkg::PSCC_25 : pscc_pkg::PSCC_2P5);
  wire pscc_pkg::pscc_rate_t rx_nxt = link_up ? rx_link : pscc_pkg::rx_nolink(clk_sel);
  wire pscc_pkg::pscc_rate_t tx_nxt = link_up ? tx_link : pscc_pkg::tx_nolink(clk_sel);

  assign ctrl_word = ctrl_r;
  assign speed_target = spd_r;
  assign rx_clk_rate = rx_r;
  assign tx_clk_rate = tx_r;

  // The serial side lives on the management clock, which may stop between frames.
  pscc_mdio_engine #(
    .PRE_LEN(pscc_pkg::PRE_LEN)
  ) u_engine (
    .mdc(mdc),
    .sys_rst(sys_rst),
    .mdio_in(mdio_in),
    .phy_addr(phy_addr),
    .shadow_word(shadow_r),
    .mir_req(mir_req_r),
    .mdio_out(mdio_out),
    .mdio_oe_n(mdio_oe_n),
    .mir_ack(mdc_ack),
    .wr_tgl(mdc_wr_tgl),
    .wr_word(mdc_wr_word)
  );

  // Register update: the strap load comes first so that a write in the same cycle wins.
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (strap_load) begin
      ctrl_nxt = strap_merge;
    end
    if (wr_apply) begin
      ctrl_nxt = wr_merge;
    end
  end

  // Control register with its hardware reset value.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r <= pscc_pkg::REG_RST;
    end else if (clk_en) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Write toggle crossing; the word itself is held still by the sender for a frame.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_s1_r <= 1'b0;
      wr_s2_r <= 1'b0;
      wr_s3_r <= 1'b0;
    end else if (clk_en) begin
      wr_s1_r <= mdc_wr_tgl;
      wr_s2_r <= wr_s1_r;
      wr_s3_r <= wr_s2_r;
    end
  end

  // Mirror handshake: a new copy is sent only after the last one was taken.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      shadow_r <= pscc_pkg::REG_RST;
      mir_req_r <= 1'b0;
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
    end else if (clk_en) begin
      ack_s1_r <= mdc_ack;
      ack_s2_r <= ack_s1_r;
      if (mir_send) begin
        shadow_r <= ctrl_r;
        mir_req_r <= ~mir_req_r;
      end
    end
  end

  // Strap pins are caught once, a few cycles after release, never under reset.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_s1_r <= 2'h0;
      strap_s2_r <= 2'h0;
      strap_s3_r <= 2'h0;
      strap_r <= 2'h0;
      strap_cnt_r <= 3'h0;
      strap_done_r <= 1'b0;
    end else if (clk_en) begin
      strap_s1_r <= {strap_config_1, strap_config_0};
      strap_s2_r <= strap_s1_r;
      strap_s3_r <= strap_s2_r;
      if (strap_s2_r == strap_s3_r) begin
        strap_r <= strap_s3_r;
      end
      if (!strap_done_r) begin
        strap_cnt_r <= strap_cnt_r + 1'b1;
      end
      if (strap_load) begin
        strap_done_r <= 1'b1;
      end
    end
  end

  // Fallback: each failed attempt uses a retry; with none left the target steps down.
  always_comb begin
    spd_nxt = spd_r;
    tries_nxt = tries_r;
    if (!an_enable || link_restart) begin
      spd_nxt = top_spd;
      tries_nxt = pscc_pkg::TRIES_ZERO;
    end else if (fail_ev) begin
      if (retry_left) begin
        tries_nxt = 3'(tries_r + 1'b1);
      end else begin
        tries_nxt = pscc_pkg::TRIES_ZERO;
        unique case (spd_r)
          pscc_pkg::PSCC_SPD_1000: begin
            if (can_100) begin
              spd_nxt = pscc_pkg::PSCC_SPD_100;
            end else if (can_10) begin
              spd_nxt = pscc_pkg::PSCC_SPD_10;
            end
          end
          pscc_pkg::PSCC_SPD_100: begin
            if (can_10) begin
              spd_nxt = pscc_pkg::PSCC_SPD_10;
            end
          end
          pscc_pkg::PSCC_SPD_10: begin
            // Lowest speed: keep retrying here.
            spd_nxt = pscc_pkg::PSCC_SPD_10;
          end
          default: begin
            spd_nxt = top_spd;
          end
        endcase
      end
    end
  end

  // Fallback state registers.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      spd_r <= pscc_pkg::PSCC_SPD_1000;
      tries_r <= pscc_pkg::TRIES_ZERO;
    end else if (clk_en) begin
      spd_r <= spd_nxt;
      tries_r <= tries_nxt;
    end
  end

  // Clock rate outputs; the reset code gives 2.5 MHz everywhere.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_r <= pscc_pkg::PSCC_2P5;
      tx_r <= pscc_pkg::PSCC_2P5;
      seen_r <= 1'b0;
    end else if (clk_en) begin
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      seen_r <= 1'b1;
    end
  end

  // Checks on the register, the fallback controller and the clock table.
  chk_reset_value: assert property (@(posedge mclk) disable iff (sys_rst)
    !seen_r |-> ctrl_r == pscc_pkg::REG_RST)
    else $error("Register does not hold its reset value after reset.");

  chk_fall_to_100: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && fail_ev && !retry_left && spd_r == pscc_pkg::PSCC_SPD_1000 && can_100)
      |=> spd_r == pscc_pkg::PSCC_SPD_100)
    else $error("Gigabit target did not fall back to 100.");

  chk_strap_load: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && strap_load && !wr_apply) |=> ctrl_r[pscc_pkg::BIT_FB100] == $past(strap_fb100))
    else $error("Strap value was not loaded into the 100 fallback enable.");

  chk_fall_to_10: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && fail_ev && !retry_left && spd_r == pscc_pkg::PSCC_SPD_100 && can_10)
      |=> spd_r == pscc_pkg::PSCC_SPD_10)
    else $error("100 target did not fall back to 10.");

  chk_reset_clock: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && clk_sel == pscc_pkg::SEL_RST && !(link_up && !link_is_1000))
      |=> tx_r == pscc_pkg::PSCC_2P5 ##0 ($past(link_up) || rx_r == pscc_pkg::PSCC_2P5))
    else $error("Default clock select does not give 2.5 MHz.");

  chk_low_codes: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && !clk_sel[2] && link_up && link_is_1000) |=> tx_r == pscc_pkg::PSCC_OFF)
    else $error("Gigabit transmit clock not off for codes 000 to 011.");

  chk_high_codes: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && clk_sel[2] && !link_up)
      |=> tx_r == ($past(clk_sel[0]) ? pscc_pkg::PSCC_25 : pscc_pkg::PSCC_2P5))
    else $error("No-link transmit clock wrong for codes 100 to 111.");

  chk_retry_count: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && fail_ev && retry_left) |=> (tries_r == $past(tries_r) + 3'h1) && $stable(spd_r))
    else $error("Failed attempt with retries left changed speed or count.");

  chk_reserved_bits: assert property (@(posedge mclk) disable iff (sys_rst)
    (ctrl_r & ~pscc_pkg::WR_MASK) == (pscc_pkg::REG_RST & ~pscc_pkg::WR_MASK))
    else $error("Reserved bits left their reset values.");

  cover_write_applied: cover property (@(posedge mclk) disable iff (sys_rst)
    clk_en && wr_apply);

  cover_fall_to_10: cover property (@(posedge mclk) disable iff (sys_rst)
    spd_r == pscc_pkg::PSCC_SPD_1000 ##[1:200] spd_r == pscc_pkg::PSCC_SPD_10);

  cover_strap_set: cover property (@(posedge mclk) disable iff (sys_rst)
    clk_en && strap_load && strap_fb100);

endmodule

// ---- hw/pscc_pkg.sv ----
// Function
// - Register at offset 0x16, resets to 0x0308.
// - Enabled fallback drops gigabit attempts to 100.
// - Strap pins choose 100 fallback default.
// - Enabled fallback drops to 10 when needed.
// - Group mode answers writes to address 31.
// - Clock select bits 3:1, default all 2.5.
// - Codes 000-011 follow the low half table.
// - Codes 100-111 follow the high half table.
// - Retry count attempts precede each fallback.
package pscc_pkg;

  // Register placement and layout.
  localparam int unsigned REG_W = 16;
  localparam logic [4:0] REG_ADDR = 5'h16;
  localparam logic [15:0] REG_RST = 16'h0308;
  // Only the fallback enables, group mode and clock select take writes.
  localparam logic [15:0] WR_MASK = 16'h0c4e;
  localparam int unsigned BIT_FB100 = 11;
  localparam int unsigned BIT_FB10 = 10;
  localparam int unsigned BIT_GROUP = 6;
  localparam int unsigned SEL_LSB = 1;
  localparam int unsigned SEL_MSB = 3;
  localparam logic [2:0] SEL_RST = 3'h4;

  // Management frame constants.
  localparam logic [4:0] GROUP_ADDR = 5'h1f;
  localparam logic [1:0] OP_WR = 2'h1;
  localparam logic [1:0] OP_RD = 2'h2;
  localparam logic [1:0] OP_ADDR = 2'h0;
  localparam int unsigned PRE_LEN = 32;
  localparam logic [4:0] HDR_LAST = 5'h0c;
  localparam logic [4:0] TA_LAST = 5'h01;
  localparam logic [4:0] DATA_LAST = 5'h0f;
  localparam logic [4:0] CNT_ZERO = 5'h00;

  // Strap capture: cycles after reset release before the strap is taken.
  localparam logic [2:0] STRAP_SETTLE = 3'h5;
  localparam logic [1:0] STRAP_FB100_CODE = 2'h3;
  localparam logic [2:0] TRIES_ZERO = 3'h0;

  // Clock rate codes presented to the clock generator.
  typedef enum logic [1:0] {
    PSCC_OFF = 2'h0,
    PSCC_2P5 = 2'h1,
    PSCC_25 = 2'h2,
    PSCC_125 = 2'h3
  } pscc_rate_t;

  // Speed target of the fallback controller.
  typedef enum logic [2:0] {
    PSCC_SPD_1000 = 3'h1,
    PSCC_SPD_100 = 3'h2,
    PSCC_SPD_10 = 3'h4
  } pscc_speed_t;

  // Serial management frame states.
  typedef enum logic [3:0] {
    PSCC_MD_IDLE = 4'h1,
    PSCC_MD_HDR = 4'h2,
    PSCC_MD_TA = 4'h4,
    PSCC_MD_DATA = 4'h8
  } pscc_mdst_t;

  // Receive clock while no link is up; same for both halves of the code space.
  function automatic pscc_rate_t rx_nolink(input logic [2:0] sel);
    case (sel[1:0])
      2'h0: rx_nolink = PSCC_2P5;
      2'h1: rx_nolink = PSCC_25;
      default: rx_nolink = PSCC_125;
    endcase
  endfunction

  // Transmit clock while no link is up.
  function automatic pscc_rate_t tx_nolink(input logic [2:0] sel);
    if (sel[2]) begin
      tx_nolink = sel[0] ? PSCC_25 : PSCC_2P5;
    end else begin
      case (sel[1:0])
        2'h0: tx_nolink = PSCC_OFF;
        2'h1: tx_nolink = PSCC_2P5;
        default: tx_nolink = PSCC_25;
      endcase
    end
  endfunction

  // Transmit clock while a gigabit link is up.
  function automatic pscc_rate_t tx_gig(input logic [2:0] sel);
    if (sel[2]) begin
      tx_gig = sel[0] ? PSCC_25 : PSCC_2P5;
    end else begin
      tx_gig = PSCC_OFF;
    end
  endfunction

endpackage

// ---- hw/pscc_mdio_engine.sv ----
// Serial management engine on the management clock.
module pscc_mdio_engine #(
  parameter int unsigned PRE_LEN = pscc_pkg::PRE_LEN
) (
  input wire logic mdc,
  input wire logic sys_rst,
  input wire logic mdio_in,
  input wire logic [4:0] phy_addr,
  input wire logic [15:0] shadow_word,
  input wire logic mir_req,
  output logic mdio_out,
  output logic mdio_oe_n,
  output logic mir_ack,
  output logic wr_tgl,
  output logic [15:0] wr_word
);

  localparam int unsigned PW = $clog2(PRE_LEN + 1);
  localparam logic [PW-1:0] PRE_FULL = PW'(PRE_LEN);

  logic rst_s1_r, rst_mdc_r; // Reset synchroniser, asserts at once, releases on mdc.
  logic [4:0] pa_s1_r, pa_s2_r, pa_s3_r, own_addr_r; // Address pin filter.
  logic req_s1_r, req_s2_r, ack_r; // Mirror handshake.
  logic [15:0] rd_word_r; // Local copy of the register.
  pscc_pkg::pscc_mdst_t state_r;
  logic [4:0] cnt_r;
  logic [PW-1:0] pre_cnt_r;
  logic [11:0] hdr_r;
  logic rd_hit_r, wr_hit_r;
  logic [15:0] sh_r;
  logic out_r, oe_n_r, wr_tgl_r;
  logic [15:0] wr_word_r;

  // Header decode happens on the last header bit, before it is stored.
  wire [12:0] hdr_full = {hdr_r, mdio_in};
  wire st_c22 = hdr_full[12];
  wire [1:0] op = hdr_full[11:10];
  wire [4:0] pa = hdr_full[9:5];
  wire [4:0] ra = hdr_full[4:0];
  wire grp_en = rd_word_r[pscc_pkg::BIT_GROUP];
  wire own_hit = (pa == own_addr_r);
  wire grp_hit = grp_en && (pa == pscc_pkg::GROUP_ADDR);
  wire is_wr = st_c22 && (op == pscc_pkg::OP_WR);
  wire is_rd = st_c22 && (op == pscc_pkg::OP_RD);
  // Reads are answered only at the own address, never through group mode: several devices would collide.
  wire hdr_wr_hit = is_wr && (ra == pscc_pkg::REG_ADDR) && (own_hit || grp_hit);
  wire hdr_rd_hit = is_rd && (ra == pscc_pkg::REG_ADDR) && own_hit;
  wire hdr_end = (state_r == pscc_pkg::PSCC_MD_HDR) && (cnt_r == pscc_pkg::HDR_LAST);
  wire [15:0] rx_word = {sh_r[14:0], mdio_in};

  assign mdio_out = out_r;
  assign mdio_oe_n = oe_n_r;
  assign mir_ack = ack_r;
  assign wr_tgl = wr_tgl_r;
  assign wr_word = wr_word_r;

  // Local reset release follows the management clock.
  always_ff @(posedge mdc or posedge sys_rst) begin
    if (sys_rst) begin
      rst_s1_r <= 1'b1;
      rst_mdc_r <= 1'b1;
    end else begin
      rst_s1_r <= 1'b0;
      rst_mdc_r <= rst_s1_r;
    end
  end

  // Address pins pass three stages; a value counts once two stages agree.
  always_ff @(posedge mdc or posedge rst_mdc_r) begin
    if (rst_mdc_r) begin
      pa_s1_r <= 5'h00;
      pa_s2_r <= 5'h00;
      pa_s3_r <= 5'h00;
      own_addr_r <= 5'h00;
    end else begin
      pa_s1_r <= phy_addr;
      pa_s2_r <= pa_s1_r;
      pa_s3_r <= pa_s2_r;
      if (pa_s2_r == pa_s3_r) begin
        own_addr_r <= pa_s3_r;
      end
    end
  end

  // The mirror word is held still by the sender until the acknowledge returns.
  always_ff @(posedge mdc or posedge rst_mdc_r) begin
    if (rst_mdc_r) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      ack_r <= 1'b0;
      rd_word_r <= pscc_pkg::REG_RST;
    end else begin
      req_s1_r <= mir_req;
      req_s2_r <= req_s1_r;
      if (req_s2_r != ack_r) begin
        rd_word_r <= shadow_word;
        ack_r <= req_s2_r;
      end
    end
  end

  // Frame sequencer; the pin is sampled and driven on the rising mdc edge.
  always_ff @(posedge mdc or posedge rst_mdc_r) begin
    if (rst_mdc_r) begin
      state_r <= pscc_pkg::PSCC_MD_IDLE;
      cnt_r <= pscc_pkg::CNT_ZERO;
      pre_cnt_r <= '0;
      hdr_r <= 12'h000;
      rd_hit_r <= 1'b0;
      wr_hit_r <= 1'b0;
      sh_r <= 16'h0000;
      out_r <= 1'b1;
      oe_n_r <= 1'b1;
      wr_tgl_r <= 1'b0;
      wr_word_r <= pscc_pkg::REG_RST;
    end else begin
      unique case (state_r)
        pscc_pkg::PSCC_MD_IDLE: begin
          // A zero after a full preamble is the first start bit.
          if (mdio_in) begin
            if (pre_cnt_r != PRE_FULL) begin
              pre_cnt_r <= pre_cnt_r + 1'b1;
            end
          end else begin
            if (pre_cnt_r == PRE_FULL) begin
              state_r <= pscc_pkg::PSCC_MD_HDR;
              cnt_r <= pscc_pkg::CNT_ZERO;
            end
            pre_cnt_r <= '0;
          end
        end
        pscc_pkg::PSCC_MD_HDR: begin
          hdr_r <= hdr_full[11:0];
          cnt_r <= cnt_r + 1'b1;
          if (hdr_end) begin
            state_r <= pscc_pkg::PSCC_MD_TA;
            cnt_r <= pscc_pkg::CNT_ZERO;
            rd_hit_r <= hdr_rd_hit;
            wr_hit_r <= hdr_wr_hit;
            sh_r <= rd_word_r;
          end
        end
        pscc_pkg::PSCC_MD_TA: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == pscc_pkg::CNT_ZERO && rd_hit_r) begin
            // Second turnaround bit is driven low by the device.
            out_r <= 1'b0;
            oe_n_r <= 1'b0;
          end
          if (cnt_r == pscc_pkg::TA_LAST) begin
            state_r <= pscc_pkg::PSCC_MD_DATA;
            cnt_r <= pscc_pkg::CNT_ZERO;
            out_r <= rd_hit_r ? sh_r[15] : 1'b1;
            sh_r <= {sh_r[14:0], 1'b0};
          end
        end
        pscc_pkg::PSCC_MD_DATA: begin
          cnt_r <= cnt_r + 1'b1;
          out_r <= rd_hit_r ? sh_r[15] : 1'b1;
          sh_r <= rx_word;
          if (cnt_r == pscc_pkg::DATA_LAST) begin
            state_r <= pscc_pkg::PSCC_MD_IDLE;
            oe_n_r <= 1'b1;
            out_r <= 1'b1;
            if (wr_hit_r) begin
              wr_word_r <= rx_word;
              wr_tgl_r <= ~wr_tgl_r;
            end
          end
        end
        default: begin
          state_r <= pscc_pkg::PSCC_MD_IDLE;
        end
      endcase
    end
  end

  // A broadcast write to this register is taken while group mode is on.
  chk_group_write_hit: assert property (@(posedge mdc) disable iff (rst_mdc_r)
    (hdr_end && is_wr && ra == pscc_pkg::REG_ADDR && grp_en
      && pa == pscc_pkg::GROUP_ADDR) |=> wr_hit_r)
    else $error("Group write to address 31 was not taken.");

  cover_read_hit: cover property (@(posedge mdc) disable iff (rst_mdc_r)
    hdr_end && hdr_rd_hit);

endmodule

// ---- bench/pscc_host_model.sv ----
// Management host on the far side: makes the management clock only while a frame runs or a clocks task runs.
module pscc_host_model (
  output logic mdc,
  output logic mdio_in,
  input wire logic mdio_out,
  input wire logic mdio_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic h_en; // High while the host drives the line.
  logic h_bit; // Level the host drives.
  // The line has a pull-up, so a released line reads 1; the device wins while it drives.
  assign mdio_in = !mdio_oe_n ? mdio_out : (h_en ? h_bit : 1'b1);
  initial begin
    mdc = 1'b0;
    h_en = 1'b0;
    h_bit = 1'b1;
  end
  // Free clock cycles with the line released, used around reset so the engine leaves it.
  task automatic clocks(input int n);
    repeat (n) begin
      #3 mdc = 1'b1;
      #3 mdc = 1'b0;
    end
  endtask
  // One whole frame: full preamble, header, turnaround and 16 data bits, MSB first.
  // Bits change after the falling edge and are read back just before the next one.
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
    input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] seq;
    seq = {32'hffffffff, 2'b01, op, pa, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 0; i < 64; i++) begin
      h_en = !(op == 2'b10 && i >= 46);
      h_bit = seq[63 - i];
      #3 mdc = 1'b1;
      #3;
      if (i >= 47 && i <= 62) begin
        rd = {rd[14:0], mdio_in};
      end
      mdc = 1'b0;
    end
    h_en = 1'b0;
  endtask
endmodule

// ---- bench/pscc_ctrl_reg_tb_top.sv ----
// Self-checking bench for the speed fallback and clock control register.
module pscc_ctrl_reg_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, sys_rst, mdc, mdio_in, mdio_out, mdio_oe_n, clk_en;
  logic strap_config_1, strap_config_0, an_enable, adv_1000, adv_100, adv_10;
  logic attempt_fail, link_restart, link_up, link_is_1000, link_is_100;
  logic [4:0] phy_addr;
  logic [2:0] retry_limit, speed_target;
  logic [15:0] ctrl_word, exp_w;
  logic [1:0] rx_clk_rate, tx_clk_rate;
  // Expected rate codes per select value: no-link receive, no-link transmit, gigabit transmit.
  logic [1:0] rxn [8] = '{2'h1, 2'h2, 2'h3, 2'h3, 2'h1, 2'h2, 2'h3, 2'h3};
  logic [1:0] txn [8] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h1, 2'h2, 2'h1, 2'h2};
  logic [1:0] txg [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h1, 2'h2};
  int fail_count = 0;
  int n_compared = 0;
  pscc_ctrl_reg i_dut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .mdc(mdc),
    .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .phy_addr(phy_addr),
    .strap_config_1(strap_config_1), .strap_config_0(strap_config_0),
    .an_enable(an_enable), .adv_1000(adv_1000), .adv_100(adv_100), .adv_10(adv_10),
    .attempt_fail(attempt_fail), .link_restart(link_restart), .link_up(link_up),
    .link_is_1000(link_is_1000), .link_is_100(link_is_100), .retry_limit(retry_limit),
    .ctrl_word(ctrl_word), .speed_target(speed_target), .rx_clk_rate(rx_clk_rate),
    .tx_clk_rate(tx_clk_rate));
  pscc_host_model i_host (.mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe_n(mdio_oe_n));
  // Only the writable fields follow a write; reserved bits keep their reset values.
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d);
    merge = (old & ~pscc_pkg::WR_MASK) | (d & pscc_pkg::WR_MASK);
  endfunction
  // Word compare.
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Small code compare for speed target and rate codes.
  task automatic cmp_code(input logic [2:0] got, input logic [2:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Write frame; the expected word moves only when the frame addresses this register.
  task automatic wr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] dummy;
    i_host.frame(2'b01, pa, ra, d, dummy);
    if (ra == 5'h16 && (pa == phy_addr || (pa == 5'h1f && exp_w[6]))) begin
      exp_w = merge(exp_w, d);
    end
    // The write lands 2 to 3 system cycles after the frame; rates follow one cycle later.
    repeat (6) @(negedge mclk);
    cmp_word(ctrl_word, exp_w);
  endtask
  // Read frame and compare the word returned on the line.
  task automatic rd_chk(input logic [4:0] pa, input logic [15:0] exp);
    logic [15:0] got;
    i_host.frame(2'b10, pa, 5'h16, 16'h0000, got);
    cmp_word(got, exp);
  endtask
  // Failed link attempts, one system cycle each.
  task automatic fails(input int n);
    repeat (n) begin
      attempt_fail = 1'b1;
      @(negedge mclk);
      attempt_fail = 1'b0;
      @(negedge mclk);
    end
  endtask
  // Restart returns the target to the highest advertised speed.
  task automatic restart();
    link_restart = 1'b1;
    @(negedge mclk);
    link_restart = 1'b0;
    @(negedge mclk);
    cmp_code(speed_target, 3'h1);
  endtask
  task automatic end_sim();
    $display("compared=%0d mismatches=%0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Guards against a hang anywhere in the sequence.
  initial begin
    #200000;
    fail_count++;
    end_sim();
  end
  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    {strap_config_1, strap_config_0} = 2'b11;
    {an_enable, attempt_fail, link_restart, link_up, link_is_1000, link_is_100} = 6'h00;
    {adv_1000, adv_100, adv_10} = 3'h7;
    retry_limit = 3'h4;
    void'($urandom(32'hb1a4));
    phy_addr = 5'($urandom_range(30, 0));
    // The management side sees its reset at once, without clock edges.
    fork
      i_host.clocks(8);
      repeat (6) @(negedge mclk);
    join
    cmp_word(ctrl_word, 16'h0308);
    sys_rst = 1'b0;
    // The management side leaves reset only on its own clock edges, before any preamble.
    i_host.clocks(4);
    repeat (8) @(negedge mclk);
    exp_w = 16'h0b08;
    cmp_word(ctrl_word, exp_w);
    rd_chk(phy_addr, exp_w);
    repeat (4) begin
      wr(phy_addr, 5'h16, 16'($urandom()));
      rd_chk(phy_addr, exp_w);
    end
    wr(phy_addr, 5'h15, 16'hffff);
    wr(phy_addr ^ 5'h01, 5'h16, 16'h0c4e);
    wr(phy_addr, 5'h16, 16'h0040);
    wr(5'h1f, 5'h16, 16'h0c48);
    rd_chk(5'h1f, 16'hffff);
    wr(5'h1f, 5'h16, 16'h0008);
    wr(5'h1f, 5'h16, 16'h004e);
    for (int s = 0; s < 8; s++) begin
      wr(phy_addr, 5'h16, 16'(s * 2));
      cmp_code({1'b0, rx_clk_rate}, {1'b0, rxn[s]});
      cmp_code({1'b0, tx_clk_rate}, {1'b0, txn[s]});
      link_up = 1'b1;
      link_is_1000 = 1'b1;
      repeat (3) @(negedge mclk);
      cmp_code({1'b0, tx_clk_rate}, {1'b0, txg[s]});
      link_up = 1'b0;
      link_is_1000 = 1'b0;
    end
    // Linked at 100 both clocks follow the line at 25 MHz.
    @(negedge mclk);
    {link_up, link_is_100} = 2'h3;
    repeat (3) @(negedge mclk);
    cmp_code({1'b0, rx_clk_rate}, 3'h2);
    cmp_code({1'b0, tx_clk_rate}, 3'h2);
    {link_up, link_is_100} = 2'h0;
    wr(phy_addr, 5'h16, 16'h0c08);
    an_enable = 1'b1;
    restart();
    fails(4);
    cmp_code(speed_target, 3'h1);
    fails(1);
    cmp_code(speed_target, 3'h2);
    fails(5);
    cmp_code(speed_target, 3'h4);
    wr(phy_addr, 5'h16, 16'h0408);
    restart();
    fails(5);
    cmp_code(speed_target, 3'h4);
    // A low clock enable freezes the target even through a restart.
    clk_en = 1'b0;
    link_restart = 1'b1;
    repeat (2) @(negedge mclk);
    link_restart = 1'b0;
    cmp_code(speed_target, 3'h4);
    @(negedge mclk);
    clk_en = 1'b1;
    restart();
    end_sim();
  end
endmodule
